// ---- uvt_core.sv ----
/*
 * UV index threshold event, status and result register logic.
 * Assumes a decoded one-cycle register access from the serial port
 * and a one-cycle sample strobe from the measurement front end.
 */
// Overview of operation
// R1: Event circuit works only when enabled
// R2: Hold bit latches event flags
// R3: Low enable requests below-threshold events
// R4: High enable requests above-threshold events
// R5: Host writes zeros to upper config bits
// R6: Any-event flag reports generated events
// R7: Low flag shows low event
// R8: High flag shows high event
// R9: Writable 8-bit threshold sets compare level
// R10: Sample sets ready flag; result read clears it
// R11: Result register holds latest index
// R12: Two-bit selector routes event pin source
// R13: Polarity and open-drain select pin drive
// R14: Single trigger starts one measurement, self-clears
// R15: Reading flags clears held events
// R16: Compare each new sample, update same cycle
`timescale 1ns/100ps
module uvt_core (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire uvt_pkg::uvt_acc_s i_acc,
    output logic [7:0] o_rdata,
    input wire uvt_pkg::uvt_smp_s i_smp,
    input wire logic i_pin_in,
    output logic o_meas_start,
    output logic o_rate_on,
    output logic o_pin_out,
    output logic o_pin_oe
);
    import uvt_pkg::*;

    logic rst_meta_reg; // Reset synchroniser first stage
    logic rst_n_reg; // Released reset copy
    logic [7:0] ctrl1_reg; // Rate control
    logic [7:0] ctrl2_reg; // Trigger control
    logic [7:0] ctrl3_reg; // Pin control
    logic [7:0] event_config_reg; // Event enables
    logic [7:0] event_flags_reg; // Event flags
    logic [7:0] threshold_reg; // compare_level
    logic [7:0] sample_status_reg; // Ready flag
    logic [7:0] index_result_reg; // Latest result
    logic [7:0] rdata_next; // Read mux
    logic low_hit; // Sample below level
    logic high_hit; // Sample above level
    logic flags_rd; // Host reads event flags
    logic res_rd; // Host reads result
    logic pin_act; // Pin source, active high
    logic [2:0] flag_next; // Next any/low/high
    logic pin_probe; // Unused pin readback

    // Write strobe for one address
    function automatic logic wr_hit(input uvt_acc_s a, input logic [6:0] adr);
        return a.wr && (a.addr == adr);
    endfunction

    // Reset release through two flops
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    assign flags_rd = i_acc.rd && (i_acc.addr == UVT_ADDR_EVFLG);
    assign res_rd = i_acc.rd && (i_acc.addr == UVT_ADDR_RES);
    assign pin_probe = i_pin_in;

    // Comparison gated by circuit enable and per-side enables
    assign low_hit = i_smp.valid && event_config_reg[UVT_CFG_CIRCUIT] //R1 R16
        && event_config_reg[UVT_CFG_LOW] && (i_smp.value < threshold_reg); //R3
    assign high_hit = i_smp.valid && event_config_reg[UVT_CFG_CIRCUIT] //R1 R16
        && event_config_reg[UVT_CFG_HIGH] && (i_smp.value > threshold_reg); //R4

    // Host writable configuration registers
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            ctrl1_reg <= UVT_RST_ZERO;
            ctrl3_reg <= UVT_RST_ZERO;
            event_config_reg <= UVT_RST_ZERO;
            threshold_reg <= UVT_RST_ZERO;
        end
        else
        begin
            if (wr_hit(i_acc, UVT_ADDR_CTRL1))
                ctrl1_reg <= i_acc.wdata;
            if (wr_hit(i_acc, UVT_ADDR_CTRL3))
                ctrl3_reg <= i_acc.wdata;
            // Upper bits stored as written; host keeps them zero
            if (wr_hit(i_acc, UVT_ADDR_EVCFG))
                event_config_reg <= i_acc.wdata; //R5
            if (wr_hit(i_acc, UVT_ADDR_THRS))
                threshold_reg <= i_acc.wdata; //R9
        end
    end

    // Single trigger: set by host, cleared when the sample lands
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            ctrl2_reg <= UVT_RST_ZERO;
        else if (wr_hit(i_acc, UVT_ADDR_CTRL2))
        begin
            // Trigger ignored while continuous mode runs
            ctrl2_reg <= i_acc.wdata;
            ctrl2_reg[UVT_CTL2_TRIG] <= i_acc.wdata[UVT_CTL2_TRIG]
                && !ctrl1_reg[UVT_CTL1_RATE]; //R14
        end
        else if (i_smp.valid)
            ctrl2_reg[UVT_CTL2_TRIG] <= 1'b0; //R14
    end

    // One-cycle start pulse to the front end on trigger write
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            o_meas_start <= 1'b0;
        else
            o_meas_start <= wr_hit(i_acc, UVT_ADDR_CTRL2)
                && i_acc.wdata[UVT_CTL2_TRIG] && !ctrl1_reg[UVT_CTL1_RATE]; //R14
    end

    assign o_rate_on = ctrl1_reg[UVT_CTL1_RATE];

    // Event flags: held or live; new event wins over read clear
    always_comb
    begin
        flag_next = event_flags_reg[2:0];
        if (event_config_reg[UVT_CFG_HOLD])
        begin
            if (flags_rd)
                flag_next = 3'h0; //R15
            flag_next[UVT_FLG_LOW] = flag_next[UVT_FLG_LOW] | low_hit; //R2 R7
            flag_next[UVT_FLG_HIGH] = flag_next[UVT_FLG_HIGH] | high_hit; //R2 R8
        end
        else if (i_smp.valid)
        begin
            // Not held: flags follow each sample's outcome
            flag_next[UVT_FLG_LOW] = low_hit; //R7
            flag_next[UVT_FLG_HIGH] = high_hit; //R8
        end
        flag_next[UVT_FLG_ANY] = flag_next[UVT_FLG_LOW] | flag_next[UVT_FLG_HIGH]; //R6
    end

    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            event_flags_reg <= UVT_RST_ZERO;
        else
            event_flags_reg <= {5'h00, flag_next};
    end

    // Result and ready flag; a new sample wins over the read clear
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            index_result_reg <= UVT_RST_ZERO;
            sample_status_reg <= UVT_RST_ZERO;
        end
        else if (i_smp.valid)
        begin
            index_result_reg <= i_smp.value; //R11
            sample_status_reg[UVT_STAT_READY] <= 1'b1; //R10
        end
        else if (res_rd)
            sample_status_reg[UVT_STAT_READY] <= 1'b0; //R10
    end

    // Read data mux, unmapped reads return zero
    always_comb
    begin
        case (i_acc.addr)
            UVT_ADDR_CTRL1: rdata_next = ctrl1_reg;
            UVT_ADDR_CTRL2: rdata_next = ctrl2_reg;
            UVT_ADDR_CTRL3: rdata_next = ctrl3_reg;
            UVT_ADDR_EVCFG: rdata_next = event_config_reg;
            UVT_ADDR_EVFLG: rdata_next = event_flags_reg;
            UVT_ADDR_THRS: rdata_next = threshold_reg;
            UVT_ADDR_STAT: rdata_next = sample_status_reg;
            UVT_ADDR_RES: rdata_next = index_result_reg;
            default: rdata_next = UVT_RST_ZERO;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            o_rdata <= UVT_RST_ZERO;
        else if (i_acc.rd)
            o_rdata <= rdata_next;
    end

    // Event pin source select
    always_comb
    begin
        case (ctrl3_reg[UVT_CTL3_SEL1:UVT_CTL3_SEL0])
            UVT_SRC_READY: pin_act = sample_status_reg[UVT_STAT_READY]; //R12
            UVT_SRC_HIGH: pin_act = event_flags_reg[UVT_FLG_HIGH]; //R12
            UVT_SRC_LOW: pin_act = event_flags_reg[UVT_FLG_LOW]; //R12
            UVT_SRC_EITHER: pin_act = event_flags_reg[UVT_FLG_ANY]; //R12
            default: pin_act = 1'b0;
        endcase
    end

    // Polarity then drive type; open drain only pulls low
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            o_pin_out <= 1'b0;
            o_pin_oe <= 1'b1;
        end
        else
        begin
            o_pin_out <= pin_act ^ ctrl3_reg[UVT_CTL3_POL]; //R13
            o_pin_oe <= !ctrl3_reg[UVT_CTL3_DRV]
                || !(pin_act ^ ctrl3_reg[UVT_CTL3_POL]); //R13
        end
    end

    // Assertions
    sequence s_sample_in;
        i_smp.valid && !res_rd;
    endsequence

    a_ready_sets: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R10
        s_sample_in |=> sample_status_reg[UVT_STAT_READY])
        else $error("ready flag not set by sample");
    a_ready_clears: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R10
        (res_rd && !i_smp.valid) |=> !sample_status_reg[UVT_STAT_READY])
        else $error("ready flag not cleared by read");
    a_result_loads: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R11
        i_smp.valid |=> index_result_reg == $past(i_smp.value))
        else $error("result not loaded");
    // Checked on the flags themselves, so a lost gate on either side shows
    a_circuit_off: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R1
        (!event_config_reg[UVT_CFG_CIRCUIT] && (event_flags_reg[2:0] == 3'h0))
        |=> event_flags_reg[2:0] == 3'h0)
        else $error("event while circuit off");
    a_low_event: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R3
        low_hit |=> event_flags_reg[UVT_FLG_LOW] && event_flags_reg[UVT_FLG_ANY])
        else $error("low event lost");
    a_high_event: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R4
        high_hit |=> event_flags_reg[UVT_FLG_HIGH] && event_flags_reg[UVT_FLG_ANY])
        else $error("high event lost");
    a_held_flags: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R2
        (event_config_reg[UVT_CFG_HOLD] && !flags_rd && event_flags_reg[UVT_FLG_LOW])
        |=> event_flags_reg[UVT_FLG_LOW])
        else $error("held low flag dropped");
    a_any_flag: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R6
        event_flags_reg[UVT_FLG_ANY]
        == (event_flags_reg[UVT_FLG_LOW] || event_flags_reg[UVT_FLG_HIGH]))
        else $error("any flag mismatch");
    a_read_clear: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R15
        (flags_rd && event_config_reg[UVT_CFG_HOLD] && !i_smp.valid)
        |=> event_flags_reg[2:0] == 3'h0)
        else $error("held flags not cleared by read");
    a_trigger_clear: assert property (@(posedge i_clk) disable iff (!rst_n_reg) //R14
        (i_smp.valid && !i_acc.wr) |=> !ctrl2_reg[UVT_CTL2_TRIG])
        else $error("trigger not self cleared");
endmodule // uvt_core

// ---- uvt_pkg.sv ----
/*
 * Package for the UV index threshold event and status block.
 * Holds register offsets, field positions, reset values and the
 * shared structs. Assumes an 8-bit register access port behind the
 * serial interface decoder.
 */
package uvt_pkg;
    // Register byte addresses
    localparam logic [6:0] UVT_ADDR_CTRL1 = 7'h20; // Rate control
    localparam logic [6:0] UVT_ADDR_CTRL2 = 7'h21; // Single trigger
    localparam logic [6:0] UVT_ADDR_CTRL3 = 7'h22; // Pin control
    localparam logic [6:0] UVT_ADDR_EVCFG = 7'h23; // event_config_reg
    localparam logic [6:0] UVT_ADDR_EVFLG = 7'h24; // event_flags_reg
    localparam logic [6:0] UVT_ADDR_THRS = 7'h25; // threshold_reg
    localparam logic [6:0] UVT_ADDR_STAT = 7'h27; // sample_status_reg
    localparam logic [6:0] UVT_ADDR_RES = 7'h28; // index_result_reg
    // Event configuration field positions
    localparam int UVT_CFG_CIRCUIT = 3; // event_circuit_on
    localparam int UVT_CFG_HOLD = 2; // hold_requests
    localparam int UVT_CFG_LOW = 1; // low_event_on
    localparam int UVT_CFG_HIGH = 0; // high_event_on
    // Event flags field positions
    localparam int UVT_FLG_ANY = 2; // any_event_flag
    localparam int UVT_FLG_LOW = 1; // low_event_flag
    localparam int UVT_FLG_HIGH = 0; // high_event_flag
    // Control and status field positions
    localparam int UVT_CTL1_RATE = 0; // continuous_rate_on
    localparam int UVT_CTL2_TRIG = 0; // Single trigger
    localparam int UVT_CTL3_POL = 7; // Active low when set
    localparam int UVT_CTL3_DRV = 6; // pin_drive_type
    localparam int UVT_CTL3_SEL1 = 1; // Source select high bit
    localparam int UVT_CTL3_SEL0 = 0; // Source select low bit
    localparam int UVT_STAT_READY = 0; // sample_ready_flag
    // Reset values
    localparam logic [7:0] UVT_RST_ZERO = 8'h00;
    // Pin source selector codes
    localparam logic [1:0] UVT_SRC_READY = 2'h0;
    localparam logic [1:0] UVT_SRC_HIGH = 2'h1;
    localparam logic [1:0] UVT_SRC_LOW = 2'h2;
    localparam logic [1:0] UVT_SRC_EITHER = 2'h3;

    // Host register access, one cycle per access
    typedef struct packed {
        logic wr; // Write strobe
        logic rd; // Read strobe
        logic [6:0] addr; // Register address
        logic [7:0] wdata; // Write data
    } uvt_acc_s;

    // Measurement front end sample
    typedef struct packed {
        logic valid; // New sample strobe
        logic [7:0] value; // UV index value
    } uvt_smp_s;
endpackage

// ---- uvt_front.sv ----
/*
 * Measurement front-end model that feeds samples into the block.
 * Assumes the bench raises its requests at the falling clock edge.
 */
`timescale 1ns/100ps
module uvt_front
(
    input wire logic i_clk,
    input wire logic i_start, // Single measurement start
    input wire logic i_req, // Bench sample request
    input wire logic [7:0] i_value, // Value to deliver
    output uvt_pkg::uvt_smp_s o_smp
);
    import uvt_pkg::*;
    logic [1:0] wait_cnt; // Conversion delay
    logic fire; // Strobe this cycle
    assign fire = i_req || (wait_cnt == 2'h1);
    initial
    begin
        o_smp = '0;
        wait_cnt = 2'h0;
    end
    // One-cycle strobe; value is scrambled outside the strobe
    always @(negedge i_clk)
    begin
        o_smp.valid <= fire;
        o_smp.value <= fire ? i_value : ~i_value;
        if (i_start)
            wait_cnt <= 2'h3;
        else if (wait_cnt != 2'h0)
            wait_cnt <= wait_cnt - 2'h1;
    end
endmodule // uvt_front

// ---- tb_uvt_core.sv ----
/*
 * Self-checking bench for the threshold event and status block.
 * Assumes one-cycle register strobes and the front-end model.
 */
`timescale 1ns/100ps
module tb_uvt_core;
    import uvt_pkg::*;
    logic clk = 1'b0; // 50 MHz clock
    logic arst_n = 1'b0; // Active-low reset
    uvt_acc_s acc = '0; // Register access
    uvt_smp_s smp; // Sample from model
    logic [7:0] rdata; // Read data
    logic meas_start, rate_on, pin_out, pin_oe;
    logic pin_wire; // Pin level with pull-up
    logic req = 1'b0; // Sample request
    logic [7:0] val = 8'h00; // Sample value
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [6:0] addrs [9] = '{7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h7f};
    logic lvl; // Expected pin level
    assign pin_wire = pin_oe ? pin_out : 1'b1;
    always #10 clk = ~clk;
    uvt_core uvt_core_inst (.i_clk(clk), .i_arst_n(arst_n), .i_acc(acc), .o_rdata(rdata),
        .i_smp(smp), .i_pin_in(pin_wire), .o_meas_start(meas_start), .o_rate_on(rate_on),
        .o_pin_out(pin_out), .o_pin_oe(pin_oe));
    uvt_front uvt_front_inst (.i_clk(clk), .i_start(meas_start), .i_req(req),
        .i_value(val), .o_smp(smp));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    // Strobes stand for exactly one rising edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk) acc = '{1'b1, 1'b0, a, d};
        @(negedge clk) acc = '0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(negedge clk) acc = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk) acc = '0;
        chk8(rdata, exp);
    endtask
    // Pin settles one cycle after the flags
    task automatic sample(input logic [7:0] v);
        @(negedge clk) val <= v;
        req <= 1'b1;
        @(negedge clk) req <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard, far above the run length
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("[FAIL] %0t run too long", $time);
            give_verdict();
        end
    end
    initial
    begin
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        foreach (addrs[i])
            rd(addrs[i], 8'h00);
        wr(UVT_ADDR_EVCFG, 8'h0e);
        rd(UVT_ADDR_EVCFG, 8'h0e);
        wr(UVT_ADDR_THRS, 8'h5a);
        rd(UVT_ADDR_THRS, 8'h5a);
        sample(8'h59);
        rd(UVT_ADDR_EVFLG, 8'h06);
        rd(UVT_ADDR_EVFLG, 8'h00);
        rd(UVT_ADDR_STAT, 8'h01);
        rd(UVT_ADDR_RES, 8'h59);
        rd(UVT_ADDR_STAT, 8'h00);
        wr(UVT_ADDR_EVCFG, 8'h09);
        sample(8'h5b);
        rd(UVT_ADDR_EVFLG, 8'h05);
        sample(8'h5a);
        rd(UVT_ADDR_EVFLG, 8'h00);
        sample(8'h10);
        rd(UVT_ADDR_EVFLG, 8'h00);
        wr(UVT_ADDR_EVCFG, 8'h06);
        sample(8'h10);
        rd(UVT_ADDR_EVFLG, 8'h00);
        wr(UVT_ADDR_THRS, 8'h08);
        wr(UVT_ADDR_EVCFG, 8'h0d);
        sample(8'h10);
        sample(8'h00);
        rd(UVT_ADDR_EVFLG, 8'h05);
        rd(UVT_ADDR_EVFLG, 8'h00);
        wr(UVT_ADDR_EVCFG, 8'h0b);
        sample(8'h10);
        // Every source code under push-pull with each polarity, and under open drain with normal polarity
        for (int i = 0; i < 12; i++)
        begin
            lvl = 4'b1011 >> (i % 4);
            lvl = lvl ^ (i / 4 == 1);
            wr(UVT_ADDR_CTRL3, {i / 4 == 1, i / 4 == 2, 4'h0, 2'(i % 4)});
            repeat (2) @(negedge clk);
            if (i / 4 == 2)
                chk1(pin_oe, ~lvl);
            else
                chk1(pin_out, lvl);
        end
        wr(UVT_ADDR_CTRL3, 8'h00);
        rd(UVT_ADDR_RES, 8'h10);
        @(negedge clk);
        chk1(pin_wire, 1'b0);
        val = 8'h77;
        wr(UVT_ADDR_CTRL2, 8'h01);
        chk1(meas_start, 1'b1);
        repeat (8) @(negedge clk);
        rd(UVT_ADDR_CTRL2, 8'h00);
        rd(UVT_ADDR_STAT, 8'h01);
        rd(UVT_ADDR_RES, 8'h77);
        wr(UVT_ADDR_CTRL1, 8'h01);
        chk1(rate_on, 1'b1);
        val = 8'h66;
        wr(UVT_ADDR_CTRL2, 8'h01);
        chk1(meas_start, 1'b0);
        repeat (8) @(negedge clk);
        rd(UVT_ADDR_RES, 8'h77);
        rd(UVT_ADDR_CTRL2, 8'h00);
        wr(UVT_ADDR_RES, 8'hff);
        rd(UVT_ADDR_RES, 8'h77);
        give_verdict();
    end
endmodule // tb_uvt_core
